// ===== modbus_slave_frame_front_end.sv
// Slave frame front end: serial RTU and TCP framing, filtering, exceptions
`timescale 1ns/1ps
module modbus_slave_frame_front_end #(
	parameter int MAX_CONN = modbus_fe_pkg::MAX_CONN_DEF
) (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic [3:0]  address_i,
	input  wire logic        read_i,
	input  wire logic        write_i,
	input  wire logic [31:0] writedata_i,
	input  wire logic [3:0]  byteenable_i,
	output logic      [31:0] readdata_o,
	output logic             waitrequest_o,
	input  wire logic        rx_i,
	input  wire logic        tcp_valid_i,
	input  wire logic        tcp_first_i,
	input  wire logic [1:0]  tcp_conn_i,
	input  wire logic [15:0] tcp_port_i,
	input  wire logic [7:0]  tcp_byte_i,
	output logic             ser_byte_valid_o,
	output logic      [7:0]  ser_byte_o,
	output logic             tcp_byte_valid_o,
	output logic      [7:0]  tcp_byte_o,
	output logic      [1:0]  tcp_byte_conn_o,
	output logic             req_valid_o,
	output logic      [7:0]  req_func_o,
	output logic             req_src_o,
	output logic      [1:0]  req_conn_o,
	output logic      [15:0] req_tid_o,
	output logic      [7:0]  req_uid_o,
	output logic             exc_valid_o,
	output logic      [7:0]  exc_func_o,
	output logic      [7:0]  exc_code_o,
	output logic             frame_drop_o
);
	import modbus_fe_pkg::*;

	logic [31:0] cfg_reg;
	logic        ack_reg;
	logic [31:0] rdata_reg;
	logic [7:0]  good_cnt_reg;
	logic [7:0]  drop_cnt_reg;
	logic [7:0]  exc_cnt_reg;
	logic [7:0]  last_func_reg;
	logic        last_src_reg;
	logic [15:0] last_tid_reg;
	logic [6:0]  slave_id;
	logic        data8;
	logic        two_stop;
	logic [1:0]  par_sel;
	logic        par_en;
	logic [2:0]  baud_code;
	logic [15:0] div_tab [BAUD_COUNT];
	logic [15:0] div;
	logic [3:0]  char_bits;
	logic [23:0] gap_lim_reg;
	logic [23:0] gap_cnt_reg;
	logic [7:0]  rx_byte;
	logic        rx_valid;
	logic        rx_err;
	logic [15:0] crc_val;
	logic        rtu_open_reg;
	logic        rtu_bad_reg;
	logic [7:0]  rtu_cnt_reg;
	logic [7:0]  rtu_addr_reg;
	logic [7:0]  rtu_fc_reg;
	logic [7:0]  hold0_reg;
	logic [7:0]  hold1_reg;
	logic [7:0]  rtu_idx;
	logic        rtu_end;
	logic        addr_ok;
	logic        crc_ok;
	logic        port_ok;
	logic [MAX_CONN-1:0] t_hit;
	logic [MAX_CONN-1:0] t_end;
	logic [MAX_CONN-1:0] t_fwd;
	logic [15:0] t_cnt   [MAX_CONN];
	logic [15:0] t_tid   [MAX_CONN];
	logic [15:0] t_proto [MAX_CONN];
	logic [15:0] t_len   [MAX_CONN];
	logic [7:0]  t_uid   [MAX_CONN];
	logic [7:0]  t_fc    [MAX_CONN];
	logic [15:0] t_idx   [MAX_CONN];
	logic [7:0]  t_fc_now [MAX_CONN];
	logic        tcp_end;
	logic [15:0] sel_tid;
	logic [15:0] sel_proto;
	logic [7:0]  sel_uid;
	logic [7:0]  sel_fc;
	logic        iss;
	logic [7:0]  iss_fc;
	logic        iss_src;
	logic [1:0]  iss_conn;
	logic [15:0] iss_tid;
	logic [7:0]  iss_uid;
	logic        iss_ok;
	logic        drop_evt;

	// Configuration fields
	assign slave_id  = cfg_reg[CFG_ID_LSB +: CFG_ID_W];
	assign data8     = cfg_reg[CFG_DATA8];
	assign two_stop  = cfg_reg[CFG_TWO_STOP];
	assign par_sel   = cfg_reg[CFG_PAR_LSB +: 2];
	assign par_en    = (par_sel == PAR_ODD) || (par_sel == PAR_EVEN);
	assign baud_code = cfg_reg[CFG_BAUD_LSB +: 3];

	for (genvar g = 0; g < BAUD_COUNT; g++) begin : g_div
		assign div_tab[g] = 16'(CLK_HZ / BAUD_TABLE[g]);
	end
	assign div = div_tab[baud_code];

	// Avalon slave, one wait state per access
	assign waitrequest_o = (read_i | write_i) & ~ack_reg;
	assign readdata_o    = rdata_reg;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ack_reg <= 1'b0;
		end else begin
			ack_reg <= (read_i | write_i) & ~ack_reg;
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			cfg_reg <= CFG_RESET;
		end else if (write_i && ack_reg && address_i == REG_CFG) begin
			for (int b = 0; b < 4; b++) begin
				if (byteenable_i[b]) begin
					cfg_reg[8*b +: 8] <= writedata_i[8*b +: 8] & CFG_MASK[8*b +: 8];
				end
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rdata_reg <= 32'h0000_0000;
		end else if (read_i && !ack_reg) begin
			unique case (address_i)
				REG_CFG:  rdata_reg <= cfg_reg;
				REG_STAT: rdata_reg <= {8'h00, exc_cnt_reg, drop_cnt_reg,
					good_cnt_reg};
				REG_LAST: rdata_reg <= {last_tid_reg, 7'h00, last_src_reg,
					last_func_reg};
				default:  rdata_reg <= 32'h0000_0000;
			endcase
		end
	end

	// Serial receive path
	uart_char_rx u_rx (
		.clk_i      (clk_i),
		.reset_i    (reset_i),
		.rx_i       (rx_i),
		.div_i      (div),
		.data8_i    (data8),
		.two_stop_i (two_stop),
		.par_en_i   (par_en),
		.par_odd_i  (par_sel == PAR_ODD),
		.byte_o     (rx_byte),
		.valid_o    (rx_valid),
		.err_o      (rx_err)
	);

	assign rtu_idx = (rtu_end || !rtu_open_reg) ? RTU_POS_ADDR : rtu_cnt_reg;

	crc16_rtu u_crc (
		.clk_i   (clk_i),
		.reset_i (reset_i),
		.valid_i (rx_valid),
		.start_i (rtu_idx == RTU_POS_ADDR),
		.byte_i  (rx_byte),
		.crc_o   (crc_val)
	);

	assign char_bits = CHAR_FIXED + (data8 ? CHAR_D8 : CHAR_D7)
		+ {3'h0, par_en} + {3'h0, two_stop};

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			gap_lim_reg <= 24'h000000;
		end else begin
			gap_lim_reg <= 24'((24'(char_bits) * 24'(div) * GAP_NUM)
				>> GAP_SHIFT);
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			gap_cnt_reg <= 24'h000000;
		end else if (rx_valid) begin
			gap_cnt_reg <= 24'h000000;
		end else if (gap_cnt_reg != 24'hFFFFFF) begin
			gap_cnt_reg <= gap_cnt_reg + 24'h000001;
		end
	end

	// TCP completion takes the cycle; a serial end waits for the next cycle with no TCP completion
	assign rtu_end = rtu_open_reg && (gap_cnt_reg >= gap_lim_reg)
		&& !tcp_end;
	assign addr_ok = (rtu_addr_reg >= ADDR_MIN) && (rtu_addr_reg <= ADDR_MAX)
		&& (rtu_addr_reg[6:0] == slave_id);
	assign crc_ok  = (crc_val == CRC_RESIDUE);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			rtu_open_reg <= 1'b0;
			rtu_bad_reg  <= 1'b0;
			rtu_cnt_reg  <= 8'h00;
			rtu_addr_reg <= 8'h00;
			rtu_fc_reg   <= 8'h00;
			hold0_reg    <= 8'h00;
			hold1_reg    <= 8'h00;
		end else begin
			if (rtu_end) begin
				rtu_open_reg <= 1'b0;
			end
			if (rx_valid) begin
				rtu_open_reg <= 1'b1;
				rtu_cnt_reg  <= (rtu_idx == 8'hFF) ? rtu_idx : rtu_idx + 8'h01;
				rtu_bad_reg  <= (rtu_idx == RTU_POS_ADDR) ? rx_err
					: (rtu_bad_reg | rx_err);
				if (rtu_idx == RTU_POS_ADDR) begin
					rtu_addr_reg <= rx_byte;
				end
				if (rtu_idx == RTU_POS_FC) begin
					rtu_fc_reg <= rx_byte;
				end
				hold1_reg <= hold0_reg;
				hold0_reg <= rx_byte;
			end
		end
	end

	// Data bytes lag two behind so the CRC pair is never forwarded
	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			ser_byte_valid_o <= 1'b0;
			ser_byte_o       <= 8'h00;
		end else begin
			ser_byte_valid_o <= rx_valid && (rtu_idx >= RTU_MIN_LEN) && addr_ok;
			ser_byte_o       <= hold1_reg;
		end
	end

	// TCP per-connection header tracking
	assign port_ok = (tcp_port_i == TCP_PORT);

	for (genvar c = 0; c < MAX_CONN; c++) begin : g_conn
		assign t_hit[c] = tcp_valid_i && port_ok
			&& (tcp_conn_i == 2'(c));
		assign t_idx[c] = tcp_first_i ? TB_TID_HI : t_cnt[c];
		assign t_fc_now[c] = (t_idx[c] == TB_FC) ? tcp_byte_i : t_fc[c];
		assign t_end[c] = t_hit[c] && (t_idx[c] >= TB_FC)
			&& (t_idx[c] + 16'h0001 == t_len[c] + TCP_LEN_BASE);
		assign t_fwd[c] = t_hit[c] && (t_idx[c] > TB_FC)
			&& (t_proto[c] == PROTO_MODBUS);

		always_ff @(posedge clk_i) begin
			if (reset_i) begin
				t_cnt[c]   <= 16'h0000;
				t_tid[c]   <= 16'h0000;
				t_proto[c] <= 16'h0000;
				t_len[c]   <= 16'h0000;
				t_uid[c]   <= 8'h00;
				t_fc[c]    <= 8'h00;
			end else if (t_hit[c]) begin
				t_cnt[c] <= t_end[c] ? TB_TID_HI : t_idx[c] + 16'h0001;
				unique case (t_idx[c])
					TB_TID_HI: t_tid[c][15:8]   <= tcp_byte_i;
					TB_TID_LO: t_tid[c][7:0]    <= tcp_byte_i;
					TB_PRO_HI: t_proto[c][15:8] <= tcp_byte_i;
					TB_PRO_LO: t_proto[c][7:0]  <= tcp_byte_i;
					TB_LEN_HI: t_len[c][15:8]   <= tcp_byte_i;
					TB_LEN_LO: t_len[c][7:0]    <= tcp_byte_i;
					TB_UID:    t_uid[c]         <= tcp_byte_i;
					TB_FC:     t_fc[c]          <= tcp_byte_i;
					default:   t_fc[c]          <= t_fc[c];
				endcase
			end
		end
	end

	assign tcp_end = |t_end;

	always_comb begin
		sel_tid   = 16'h0000;
		sel_proto = 16'h0000;
		sel_uid   = 8'h00;
		sel_fc    = 8'h00;
		for (int c = 0; c < MAX_CONN; c++) begin
			if (t_end[c]) begin
				sel_tid   = t_tid[c];
				sel_proto = t_proto[c];
				sel_uid   = t_uid[c];
				sel_fc    = t_fc_now[c];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			tcp_byte_valid_o <= 1'b0;
			tcp_byte_o       <= 8'h00;
			tcp_byte_conn_o  <= 2'h0;
		end else begin
			tcp_byte_valid_o <= |t_fwd;
			tcp_byte_o       <= tcp_byte_i;
			tcp_byte_conn_o  <= tcp_conn_i;
		end
	end

	// Request issue, common to both transports
	always_comb begin
		iss      = 1'b0;
		iss_fc   = 8'h00;
		iss_src  = SRC_SERIAL;
		iss_conn = 2'h0;
		iss_tid  = 16'h0000;
		iss_uid  = 8'h00;
		drop_evt = 1'b0;
		if (tcp_end) begin
			iss      = (sel_proto == PROTO_MODBUS);
			iss_fc   = sel_fc;
			iss_src  = SRC_TCP;
			iss_conn = tcp_conn_i;
			iss_tid  = sel_tid;
			iss_uid  = sel_uid;
		end else if (rtu_end) begin
			iss      = (rtu_cnt_reg >= RTU_MIN_LEN) && !rtu_bad_reg && crc_ok
				&& addr_ok;
			iss_fc   = rtu_fc_reg;
			iss_uid  = rtu_addr_reg;
			drop_evt = (rtu_cnt_reg >= RTU_MIN_LEN)
				&& (rtu_bad_reg || !crc_ok);
		end
	end

	assign iss_ok = fc_supported(iss_fc);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			req_valid_o  <= 1'b0;
			exc_valid_o  <= 1'b0;
			frame_drop_o <= 1'b0;
			req_func_o   <= 8'h00;
			req_src_o    <= SRC_SERIAL;
			req_conn_o   <= 2'h0;
			req_tid_o    <= 16'h0000;
			req_uid_o    <= 8'h00;
			exc_func_o   <= 8'h00;
			exc_code_o   <= 8'h00;
		end else begin
			req_valid_o  <= iss && iss_ok;
			exc_valid_o  <= iss && !iss_ok;
			frame_drop_o <= drop_evt;
			if (iss) begin
				req_func_o <= iss_fc;
				req_src_o  <= iss_src;
				req_conn_o <= iss_conn;
				req_tid_o  <= iss_tid;
				req_uid_o  <= iss_uid;
				exc_func_o <= iss_fc | EXC_FLAG;
				exc_code_o <= EXC_ILL_FUNC;
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			good_cnt_reg  <= 8'h00;
			drop_cnt_reg  <= 8'h00;
			exc_cnt_reg   <= 8'h00;
			last_func_reg <= 8'h00;
			last_src_reg  <= SRC_SERIAL;
			last_tid_reg  <= 16'h0000;
		end else begin
			if (iss && iss_ok) begin
				good_cnt_reg <= good_cnt_reg + 8'h01;
			end
			if (iss && !iss_ok) begin
				exc_cnt_reg <= exc_cnt_reg + 8'h01;
			end
			if (drop_evt) begin
				drop_cnt_reg <= drop_cnt_reg + 8'h01;
			end
			if (iss) begin
				last_func_reg <= iss_fc;
				last_src_reg  <= iss_src;
				last_tid_reg  <= iss_tid;
			end
		end
	end

	// Checks
	a_exc_func_flag: assert property (@(posedge clk_i) disable iff (reset_i)
		exc_valid_o |-> exc_func_o == ($past(iss_fc) | EXC_FLAG))
		else $error("exception function not flagged");
	a_exc_code_val: assert property (@(posedge clk_i) disable iff (reset_i)
		exc_valid_o |-> exc_code_o == EXC_ILL_FUNC)
		else $error("wrong exception code");
	a_req_fc_range: assert property (@(posedge clk_i) disable iff (reset_i)
		req_valid_o |-> req_func_o >= FC_MIN && req_func_o <= FC_MAX)
		else $error("unsupported function passed");
	a_bad_fc_exc: assert property (@(posedge clk_i) disable iff (reset_i)
		iss && !iss_ok |=> exc_valid_o && !req_valid_o)
		else $error("bad function not excepted");
	a_ser_addr_ok: assert property (@(posedge clk_i) disable iff (reset_i)
		(req_valid_o || exc_valid_o) && req_src_o == SRC_SERIAL
		|-> req_uid_o >= ADDR_MIN && req_uid_o <= ADDR_MAX
		&& req_uid_o[6:0] == slave_id)
		else $error("serial address filter failed");
	a_crc_drop: assert property (@(posedge clk_i) disable iff (reset_i)
		rtu_end && !crc_ok |=> !req_valid_o && !exc_valid_o
		&& frame_drop_o == ($past(rtu_cnt_reg) >= RTU_MIN_LEN))
		else $error("bad crc frame not dropped");
	a_tid_echo: assert property (@(posedge clk_i) disable iff (reset_i)
		tcp_end && sel_proto == PROTO_MODBUS |=> req_src_o == SRC_TCP
		&& req_tid_o == $past(sel_tid) && req_uid_o == $past(sel_uid))
		else $error("tcp header not echoed");
	a_port_filter: assert property (@(posedge clk_i) disable iff (reset_i)
		tcp_valid_i && !port_ok |=> !tcp_byte_valid_o)
		else $error("foreign port accepted");
	a_conn_limit: assert property (@(posedge clk_i) disable iff (reset_i)
		tcp_valid_i && 32'(tcp_conn_i) >= MAX_CONN |=> !tcp_byte_valid_o
		&& !((req_valid_o || exc_valid_o) && req_src_o == SRC_TCP))
		else $error("extra connection served");
	a_baud_default: assert property (@(posedge clk_i)
		$fell(reset_i) |-> baud_code == BAUD_DEFAULT)
		else $error("baud not default after reset");
	a_bus_one_wait: assert property (@(posedge clk_i) disable iff (reset_i)
		(read_i || write_i) && waitrequest_o |=> !waitrequest_o)
		else $error("bus wait too long");

	c_ser_req: cover property (@(posedge clk_i) disable iff (reset_i)
		req_valid_o && req_src_o == SRC_SERIAL);
	c_tcp_req: cover property (@(posedge clk_i) disable iff (reset_i)
		req_valid_o && req_src_o == SRC_TCP);
	c_exc: cover property (@(posedge clk_i) disable iff (reset_i)
		exc_valid_o);
	c_drop: cover property (@(posedge clk_i) disable iff (reset_i)
		frame_drop_o);
endmodule

// ===== modbus_fe_pkg.sv
// Shared constants and types for the serial and TCP frame front end
package modbus_fe_pkg;

	localparam int          CLK_HZ        = 40_000_000;
	localparam int          MAX_CONN_DEF  = 3;

	localparam int          BAUD_COUNT    = 8;
	localparam int          BAUD_TABLE [BAUD_COUNT] = '{
		1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200
	};
	localparam logic [2:0]  BAUD_DEFAULT  = 3'h3;

	typedef enum logic [1:0] {
		PAR_NONE = 2'b00,
		PAR_ODD  = 2'b01,
		PAR_EVEN = 2'b10
	} parity_t;

	localparam logic [7:0]  ADDR_MIN      = 8'h01;
	localparam logic [7:0]  ADDR_MAX      = 8'h7F;
	localparam logic [7:0]  FC_MIN        = 8'h01;
	localparam logic [7:0]  FC_MAX        = 8'h06;
	localparam logic [7:0]  EXC_FLAG      = 8'h80;
	localparam logic [7:0]  EXC_ILL_FUNC  = 8'h01;
	localparam logic [7:0]  EXC_ILL_ADDR  = 8'h02;
	localparam logic [7:0]  EXC_ILL_DATA  = 8'h03;
	localparam logic [7:0]  EXC_DEV_FAIL  = 8'h04;

	localparam logic [15:0] TCP_PORT      = 16'h01F6;
	localparam logic [15:0] PROTO_MODBUS  = 16'h0000;
	localparam logic [15:0] TB_TID_HI     = 16'h0000;
	localparam logic [15:0] TB_TID_LO     = 16'h0001;
	localparam logic [15:0] TB_PRO_HI     = 16'h0002;
	localparam logic [15:0] TB_PRO_LO     = 16'h0003;
	localparam logic [15:0] TB_LEN_HI     = 16'h0004;
	localparam logic [15:0] TB_LEN_LO     = 16'h0005;
	localparam logic [15:0] TB_UID        = 16'h0006;
	localparam logic [15:0] TB_FC         = 16'h0007;
	localparam logic [15:0] TCP_LEN_BASE  = 16'h0006;

	localparam logic [7:0]  RTU_POS_ADDR  = 8'h00;
	localparam logic [7:0]  RTU_POS_FC    = 8'h01;
	localparam logic [7:0]  RTU_MIN_LEN   = 8'h04;

	localparam logic [15:0] CRC_POLY      = 16'hA001;
	localparam logic [15:0] CRC_INIT      = 16'hFFFF;
	localparam logic [15:0] CRC_RESIDUE   = 16'h0000;

	localparam logic [3:0]  REG_CFG       = 4'h0;
	localparam logic [3:0]  REG_STAT      = 4'h4;
	localparam logic [3:0]  REG_LAST      = 4'h8;

	localparam int          CFG_ID_LSB    = 0;
	localparam int          CFG_ID_W      = 7;
	localparam int          CFG_DATA8     = 8;
	localparam int          CFG_TWO_STOP  = 9;
	localparam int          CFG_PAR_LSB   = 10;
	localparam int          CFG_BAUD_LSB  = 12;
	localparam logic [31:0] CFG_RESET     = 32'h0000_3101;
	localparam logic [31:0] CFG_MASK      = 32'h0000_7F7F;

	localparam logic [3:0]  CHAR_FIXED    = 4'h2;
	localparam logic [3:0]  CHAR_D7       = 4'h7;
	localparam logic [3:0]  CHAR_D8       = 4'h8;
	localparam logic [23:0] GAP_NUM       = 24'h000007;
	localparam int          GAP_SHIFT     = 1;

	localparam logic        SRC_SERIAL    = 1'b0;
	localparam logic        SRC_TCP       = 1'b1;

	function automatic logic fc_supported(input logic [7:0] fc);
		return (fc >= FC_MIN) && (fc <= FC_MAX);
	endfunction

endpackage

// ===== crc16_rtu.sv
// Running reflected CRC-16 over received serial bytes
`timescale 1ns/1ps
module crc16_rtu (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        valid_i,
	input  wire logic        start_i,
	input  wire logic [7:0]  byte_i,
	output logic      [15:0] crc_o
);
	import modbus_fe_pkg::*;

	logic [15:0] crc_reg;
	logic [15:0] base;

	function automatic logic [15:0] step(input logic [15:0] c,
		input logic [7:0] b);
		logic [15:0] r;
		r = c ^ {8'h00, b};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	assign base = start_i ? CRC_INIT : crc_reg;

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			crc_reg <= CRC_INIT;
		end else if (valid_i) begin
			crc_reg <= step(base, byte_i);
		end
	end

	assign crc_o = crc_reg;
endmodule

// ===== uart_char_rx.sv
// Serial character receiver with configurable data, parity and stop bits
`timescale 1ns/1ps
module uart_char_rx (
	input  wire logic        clk_i,
	input  wire logic        reset_i,
	input  wire logic        rx_i,
	input  wire logic [15:0] div_i,
	input  wire logic        data8_i,
	input  wire logic        two_stop_i,
	input  wire logic        par_en_i,
	input  wire logic        par_odd_i,
	output logic      [7:0]  byte_o,
	output logic             valid_o,
	output logic             err_o
);
	import modbus_fe_pkg::*;

	typedef enum logic [2:0] {
		S_IDLE  = 3'b000,
		S_START = 3'b001,
		S_DATA  = 3'b010,
		S_PAR   = 3'b011,
		S_STOP  = 3'b100
	} rx_state_t;

	rx_state_t   state_reg;
	logic [15:0] cnt_reg;
	logic [3:0]  idx_reg;
	logic [7:0]  sr_reg;
	logic        acc_reg;
	logic        perr_reg;
	logic        stop2_reg;
	logic [7:0]  byte_reg;
	logic        valid_reg;
	logic        err_reg;
	logic [3:0]  last_idx;
	logic        tick;

	assign last_idx = data8_i ? (CHAR_D8 - 4'h1) : (CHAR_D7 - 4'h1);
	assign tick     = (cnt_reg == 16'h0000);

	always_ff @(posedge clk_i) begin
		if (reset_i) begin
			state_reg <= S_IDLE;
			cnt_reg   <= 16'h0000;
			idx_reg   <= 4'h0;
			sr_reg    <= 8'h00;
			acc_reg   <= 1'b0;
			perr_reg  <= 1'b0;
			stop2_reg <= 1'b0;
			byte_reg  <= 8'h00;
			valid_reg <= 1'b0;
			err_reg   <= 1'b0;
		end else begin
			valid_reg <= 1'b0;
			err_reg   <= 1'b0;
			if (!tick) begin
				cnt_reg <= cnt_reg - 16'h0001;
			end
			unique case (state_reg)
				S_IDLE: begin
					if (!rx_i) begin
						cnt_reg   <= div_i >> 1;
						state_reg <= S_START;
					end
				end
				S_START: begin
					if (tick) begin
						cnt_reg   <= div_i - 16'h0001;
						idx_reg   <= 4'h0;
						acc_reg   <= 1'b0;
						perr_reg  <= 1'b0;
						stop2_reg <= 1'b0;
						state_reg <= rx_i ? S_IDLE : S_DATA;
					end
				end
				S_DATA: begin
					if (tick) begin
						cnt_reg <= div_i - 16'h0001;
						sr_reg  <= {rx_i, sr_reg[7:1]};
						acc_reg <= acc_reg ^ rx_i;
						idx_reg <= idx_reg + 4'h1;
						if (idx_reg == last_idx) begin
							state_reg <= par_en_i ? S_PAR : S_STOP;
						end
					end
				end
				S_PAR: begin
					if (tick) begin
						cnt_reg   <= div_i - 16'h0001;
						perr_reg  <= (acc_reg ^ rx_i) != par_odd_i;
						state_reg <= S_STOP;
					end
				end
				S_STOP: begin
					if (tick) begin
						cnt_reg <= div_i - 16'h0001;
						if (two_stop_i && !stop2_reg) begin
							stop2_reg <= 1'b1;
							perr_reg  <= perr_reg | !rx_i;
						end else begin
							byte_reg  <= data8_i ? sr_reg : {1'b0, sr_reg[7:1]};
							valid_reg <= 1'b1;
							err_reg   <= perr_reg | !rx_i;
							state_reg <= S_IDLE;
						end
					end
				end
			endcase
		end
	end

	assign byte_o  = byte_reg;
	assign valid_o = valid_reg;
	assign err_o   = err_reg;
endmodule

// ===== modbus_master_model.sv
// Remote master model sending serial and TCP request bytes
`timescale 1ns/1ps
module modbus_master_model (
	input  wire logic        clk_i,
	output logic             rx_o,
	output logic             tcp_valid_o,
	output logic             tcp_first_o,
	output logic      [1:0]  tcp_conn_o,
	output logic      [15:0] tcp_port_o,
	output logic      [7:0]  tcp_byte_o
);
	initial begin
		rx_o = 1'b1;
		tcp_valid_o = 1'b0;
		tcp_first_o = 1'b0;
		tcp_conn_o = 2'h0;
		tcp_port_o = 16'h0000;
		tcp_byte_o = 8'h00;
	end
	// Sends one character, start bit, LSB first, one stop bit
	task automatic ser_byte(input logic [7:0] b, input int div);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			rx_o <= f[i];
			repeat (div) @(posedge clk_i);
		end
	endtask
	// Sends header, unit, function code; no trailing check bytes
	task automatic tcp_send(input logic [1:0] c, input logic [15:0] p,
		input logic [7:0] m [8]);
		for (int i = 0; i < 8; i++) begin
			tcp_valid_o <= 1'b1;
			tcp_first_o <= (i == 0);
			tcp_conn_o <= c;
			tcp_port_o <= p;
			tcp_byte_o <= m[i];
			@(posedge clk_i);
		end
		tcp_valid_o <= 1'b0;
		tcp_byte_o <= ~m[7];
		@(posedge clk_i);
	endtask
endmodule

// ===== modbus_slave_frame_front_end_tb_top.sv
// Self-checking bench for the slave frame front end
`timescale 1ns/1ps
module modbus_slave_frame_front_end_tb_top;
	import modbus_fe_pkg::*;
	logic        clk_i, reset_i, read_i, write_i, rx_i, wreq, rv, ev;
	logic        tv, tf, src, ev_q;
	logic [1:0]  tc, c;
	logic [3:0]  address_i;
	logic [7:0]  tb, uid, rf, ef, ec, ru;
	logic [7:0]  m [8];
	logic [7:0]  adr [3];
	logic [15:0] tp, tid, rt, cr;
	logic [31:0] writedata_i, rdata, rd;
	logic [41:0] exp_q [$];
	int          fail_count, comparisons, seed;
	modbus_master_model mm (.clk_i(clk_i), .rx_o(rx_i), .tcp_valid_o(tv),
		.tcp_first_o(tf), .tcp_conn_o(tc), .tcp_port_o(tp), .tcp_byte_o(tb));
	modbus_slave_frame_front_end modbus_slave_frame_front_end_inst (
		.clk_i(clk_i), .reset_i(reset_i), .address_i(address_i),
		.read_i(read_i), .write_i(write_i), .writedata_i(writedata_i),
		.byteenable_i(4'hF), .readdata_o(rdata), .waitrequest_o(wreq),
		.rx_i(rx_i), .tcp_valid_i(tv), .tcp_first_i(tf), .tcp_conn_i(tc),
		.tcp_port_i(tp), .tcp_byte_i(tb), .ser_byte_valid_o(),
		.ser_byte_o(), .tcp_byte_valid_o(), .tcp_byte_o(),
		.tcp_byte_conn_o(), .req_valid_o(rv), .req_func_o(rf),
		.req_src_o(src), .req_conn_o(), .req_tid_o(rt), .req_uid_o(ru),
		.exc_valid_o(ev), .exc_func_o(ef), .exc_code_o(ec),
		.frame_drop_o());
	task automatic chk(input string n, input logic [41:0] e, s);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask
	task automatic bus(input logic w, input logic [3:0] a,
		input logic [31:0] d, output logic [31:0] q);
		read_i <= !w;
		write_i <= w;
		address_i <= a;
		writedata_i <= d;
		do @(posedge clk_i); while (wreq !== 1'b0);
		q = rdata;
		read_i <= 1'b0;
		write_i <= 1'b0;
		@(posedge clk_i);
	endtask
	function automatic logic [15:0] crc(input logic [7:0] a, b);
		logic [15:0] r;
		r = 16'hFFFF;
		for (int i = 0; i < 16; i++) begin
			if (i % 8 == 0) r ^= (i < 8) ? a : b;
			r = r[0] ? (r >> 1) ^ 16'hA001 : r >> 1;
		end
		return r;
	endfunction
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask
	initial begin
		clk_i = 1'b0;
		forever #12.5 clk_i = ~clk_i;
	end
	always @(negedge clk_i) begin
		ev_q = (ev === 1'b1);
		if (rv === 1'b1 || ev_q) begin
			if (exp_q.size() == 0) chk("unexpected", '0, 42'h1);
			else chk("result", exp_q.pop_front(), {ev, ev_q ? ef : rf,
				ev_q ? ec : 8'h00, src, rt, ru});
		end
	end
	initial begin
		repeat (90000) @(posedge clk_i);
		fail_count++;
		tally_and_finish();
	end
	initial begin
		seed = 44;
		reset_i = 1'b1;
		read_i = 1'b0;
		write_i = 1'b0;
		address_i = 4'h0;
		writedata_i = 32'h0;
		repeat (10) @(posedge clk_i);
		reset_i <= 1'b0;
		bus(1'b0, REG_CFG, 32'h0, rd);
		chk("cfg reset", 42'(CFG_RESET), 42'(rd));
		bus(1'b0, 4'hC, 32'h0, rd);
		chk("unmapped", '0, 42'(rd));
		$display("test registers done");
		for (int f = 0; f < 9; f++) begin
			tid = 16'($random(seed));
			uid = 8'($random(seed));
			c = 2'($unsigned($random(seed)) % 3);
			m = '{tid[15:8], tid[7:0], 8'h00, 8'h00, 8'h00, 8'h02, uid, 8'(f)};
			if (f inside {[1:6]}) exp_q.push_back({1'b0, 8'(f), 8'h00, 1'b1,
				tid, uid});
			else if (f < 8) exp_q.push_back({1'b1, 8'(f) | 8'h80, 8'h01,
				1'b1, tid, uid});
			mm.tcp_send(c, f == 8 ? 16'h01F7 : TCP_PORT, m);
		end
		$display("test tcp done");
		bus(1'b1, REG_CFG, 32'h0000_7111, rd);
		bus(1'b0, REG_CFG, 32'h0, rd);
		chk("cfg write", 42'h7111, 42'(rd));
		adr = '{8'h11, 8'h00, 8'h80};
		foreach (adr[k]) begin
			cr = crc(adr[k], 8'h03);
			if (k == 0) exp_q.push_back({1'b0, 8'h03, 8'h00, 1'b0, 16'h0,
				adr[k]});
			mm.ser_byte(adr[k], CLK_HZ / BAUD_TABLE[7]);
			mm.ser_byte(8'h03, CLK_HZ / BAUD_TABLE[7]);
			mm.ser_byte(cr[7:0], CLK_HZ / BAUD_TABLE[7]);
			mm.ser_byte(cr[15:8], CLK_HZ / BAUD_TABLE[7]);
			repeat (13000) @(posedge clk_i);
		end
		$display("test serial done");
		chk("pending", '0, 42'(exp_q.size()));
		bus(1'b0, REG_STAT, 32'h0, rd);
		chk("status counts", 42'h0002_0007, 42'(rd));
		tally_and_finish();
	end
endmodule
